// >>> core/rsw_pkg.sv
package rsw_pkg;

	// Register offsets
	localparam logic [7:0] OPT_OFS = 8'h39;
	localparam logic [7:0] SVC_OFS = 8'h3a;
	localparam logic [7:0] STAT_OFS = 8'h3b;
	localparam logic [7:0] TEST_OFS = 8'h3c;

	// System options layout
	localparam logic [7:0] OPT_RST = 8'h10;
	localparam logic [7:0] OPT_PROT_MASK = 8'h37;
	localparam int OPT_CME = 3;
	localparam int OPT_CLK_MONITOR_FORCE = 2;
	localparam int OPT_CR_LSB = 0;

	// Status layout
	localparam int STAT_CAUSE_LSB = 0;
	localparam int STAT_WDEN = 2;
	localparam int STAT_ARMED = 3;
	localparam int STAT_MONEN = 4;

	// Watchdog-reset inhibit bit in the test register
	localparam int TEST_INHIBIT = 0;

	// Watchdog service keys
	localparam logic [7:0] SVC_ARM = 8'h55;
	localparam logic [7:0] SVC_CLR = 8'haa;

	// Cycle counts
	localparam logic [11:0] POR_CYC = 12'd4064;
	localparam logic [2:0] DRIVE_CYC = 3'd4;
	localparam logic [2:0] GAP_CYC = 3'd2;
	localparam logic [6:0] PROT_CYC = 7'd64;
	localparam int PRESC_BITS = 15;

	// Vectors
	localparam logic [15:0] VEC_NORM = 16'hfffe;
	localparam logic [15:0] VEC_SPEC = 16'hbffe;
	localparam logic [15:0] VEC_CMON_OFS = 16'h0002;
	localparam logic [15:0] VEC_WDOG_OFS = 16'h0004;

	typedef enum logic [1:0] {
		CAUSE_POR,
		CAUSE_PIN,
		CAUSE_CMON,
		CAUSE_WDOG
	} rsw_cause_t;

	typedef enum logic [2:0] {
		ST_POR,
		ST_HOLD,
		ST_DRIVE,
		ST_GAP,
		ST_EXT,
		ST_RUN
	} rsw_state_t;

endpackage

// >>> core/rsw_reset_ctrl.sv
// The strobed register port is this design's own decision.
`timescale 1ns/1ps

module rsw_reset_ctrl (
	// Clock and power-on reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData_r,
	// Open-drain reset pin
	input wire logic rstPinIn,
	output logic rstPinOut_r,
	output logic rstPinOe_b_r,
	// Straps
	input wire logic wdDisableCfg,
	input wire logic specialMode,
	// Clock monitor RC cell
	input wire logic clkMonRcExpired,
	// Core side
	output logic coreReset_r,
	output logic [15:0] resetVector_r,
	output logic [7:0] sysOptions_r
);
	import rsw_pkg::*;

	function automatic logic [6:0] divFor(input logic [1:0] cr);
		divFor = 7'd1 << {cr, 1'b0};
	endfunction

	function automatic logic [15:0] vecFor(input rsw_cause_t c,
		input logic spec);
		logic [15:0] base;
		base = spec ? VEC_SPEC : VEC_NORM;
		case (c)
			CAUSE_CMON: vecFor = base - VEC_CMON_OFS;
			CAUSE_WDOG: vecFor = base - VEC_WDOG_OFS;
			default: vecFor = base;
		endcase
	endfunction

	logic rstMeta_b;
	logic rstSync_b;
	rsw_state_t state_r;
	rsw_state_t state_nxt;
	logic [11:0] cnt_r;
	logic [11:0] cnt_nxt;
	rsw_cause_t cause_r;
	rsw_cause_t cause_nxt;
	logic wdDisLatched_r;
	logic specLatched_r;
	logic inhibit_r;
	logic armed_r;
	logic [PRESC_BITS-1:0] presc_r;
	logic [6:0] wdCnt_r;
	logic [6:0] protCnt_r;
	logic optWritten_r;

	// Power-on reset release
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rstMeta_b <= 1'b0;
			rstSync_b <= 1'b0;
		end
		else
		begin
			rstMeta_b <= 1'b1;
			rstSync_b <= rstMeta_b;
		end
	end

	// Decode
	wire optWr = regWr && regAddr == OPT_OFS && !coreReset_r;
	wire svcWr = regWr && regAddr == SVC_OFS && !coreReset_r;
	wire testWr = regWr && regAddr == TEST_OFS && !coreReset_r;
	wire svcArm = svcWr && regWrData == SVC_ARM;
	wire svcClr = svcWr && regWrData == SVC_CLR && armed_r;
	wire [1:0] rateSel = sysOptions_r[OPT_CR_LSB +: 2];
	wire [6:0] rateDiv = divFor(rateSel);
	wire tick = &presc_r;
	wire wdEn = !wdDisLatched_r && !inhibit_r;
	// One extra tick absorbs the free-running prescaler phase
	wire wdExpire = tick && wdCnt_r == rateDiv;
	wire wdTimeout = wdEn && wdExpire;
	wire monEn = sysOptions_r[OPT_CME] | sysOptions_r[OPT_CLK_MONITOR_FORCE];
	wire monFail = monEn && clkMonRcExpired;
	wire protOpen = specLatched_r ||
		(protCnt_r < PROT_CYC && !optWritten_r);
	wire [7:0] protBits = protOpen ? (regWrData & OPT_PROT_MASK) :
		(sysOptions_r & OPT_PROT_MASK);
	wire [7:0] optMerged = (regWrData & ~OPT_PROT_MASK) | protBits;
	wire [7:0] optNew = optMerged |
		(sysOptions_r & (8'h01 << OPT_CLK_MONITOR_FORCE));
	wire [7:0] statByte = {3'h0, monEn, armed_r, wdEn, cause_r};
	wire [7:0] rdMux = regAddr == OPT_OFS ? sysOptions_r :
		regAddr == STAT_OFS ? statByte :
		regAddr == TEST_OFS ? {7'h00, inhibit_r} : 8'h00;

	// Reset sequencer
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r + 12'd1;
		cause_nxt = cause_r;
		case (state_r)
			ST_POR:
			begin
				if (cnt_r == POR_CYC - 12'd1)
				begin
					cnt_nxt = 12'd0;
					state_nxt = rstPinIn ? ST_RUN : ST_HOLD;
				end
			end
			ST_HOLD:
			begin
				cnt_nxt = 12'd0;
				if (rstPinIn)
					state_nxt = ST_RUN;
			end
			ST_DRIVE:
			begin
				if (cnt_r == {9'h000, DRIVE_CYC} - 12'd1)
				begin
					cnt_nxt = 12'd0;
					state_nxt = ST_GAP;
				end
			end
			ST_GAP:
			begin
				if (cnt_r == {9'h000, GAP_CYC} - 12'd1)
				begin
					cnt_nxt = 12'd0;
					if (!rstPinIn)
					begin
						cause_nxt = CAUSE_PIN;
						state_nxt = ST_EXT;
					end
					else
						state_nxt = ST_RUN;
				end
			end
			ST_EXT:
			begin
				cnt_nxt = 12'd0;
				if (rstPinIn)
					state_nxt = ST_RUN;
			end
			ST_RUN:
			begin
				cnt_nxt = 12'd0;
				if (!rstPinIn)
				begin
					cause_nxt = CAUSE_PIN;
					state_nxt = ST_DRIVE;
				end
				else if (monFail)
				begin
					cause_nxt = CAUSE_CMON;
					state_nxt = ST_DRIVE;
				end
				else if (wdTimeout)
				begin
					cause_nxt = CAUSE_WDOG;
					state_nxt = ST_DRIVE;
				end
			end
			default:
			begin
				cnt_nxt = 12'd0;
				state_nxt = ST_POR;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
		begin
			state_r <= ST_POR;
			cnt_r <= 12'd0;
			cause_r <= CAUSE_POR;
			coreReset_r <= 1'b1;
			rstPinOut_r <= 1'b0;
			rstPinOe_b_r <= 1'b1;
			resetVector_r <= VEC_NORM;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			cause_r <= cause_nxt;
			coreReset_r <= state_nxt != ST_RUN;
			rstPinOut_r <= 1'b0;
			rstPinOe_b_r <= state_nxt != ST_DRIVE;
			resetVector_r <= vecFor(cause_nxt, specLatched_r);
		end
	end

	// Straps and inhibit, taken while the core is held
	always_ff @(posedge core_clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
		begin
			wdDisLatched_r <= 1'b1;
			specLatched_r <= 1'b0;
			inhibit_r <= 1'b1;
		end
		else if (coreReset_r)
		begin
			wdDisLatched_r <= wdDisableCfg;
			specLatched_r <= specialMode;
			inhibit_r <= specialMode;
		end
		else if (testWr && specLatched_r)
			inhibit_r <= regWrData[TEST_INHIBIT];
	end

	// System options and write protection
	always_ff @(posedge core_clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
		begin
			sysOptions_r <= OPT_RST;
			protCnt_r <= 7'd0;
			optWritten_r <= 1'b0;
		end
		else if (coreReset_r)
		begin
			sysOptions_r <= OPT_RST;
			protCnt_r <= 7'd0;
			optWritten_r <= 1'b0;
		end
		else
		begin
			if (protCnt_r < PROT_CYC)
				protCnt_r <= protCnt_r + 7'd1;
			if (optWr)
			begin
				sysOptions_r <= optNew;
				optWritten_r <= 1'b1;
			end
		end
	end

	// Watchdog
	always_ff @(posedge core_clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
		begin
			presc_r <= '0;
			wdCnt_r <= 7'd0;
			armed_r <= 1'b0;
		end
		else if (coreReset_r)
		begin
			presc_r <= '0;
			wdCnt_r <= 7'd0;
			armed_r <= 1'b0;
		end
		else
		begin
			presc_r <= presc_r + 1'b1;
			if (svcClr)
			begin
				wdCnt_r <= 7'd0;
				armed_r <= 1'b0;
			end
			else
			begin
				if (tick && wdCnt_r < rateDiv)
					wdCnt_r <= wdCnt_r + 7'd1;
				if (svcArm)
					armed_r <= 1'b1;
			end
		end
	end

	// Register read, data one cycle after the strobe
	always_ff @(posedge core_clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
			regRdData_r <= 8'h00;
		else
			regRdData_r <= regRd ? rdMux : 8'h00;
	end

	// Cycles since last service, for the timeout check
	logic [22:0] sinceClr_r;
	always_ff @(posedge core_clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
			sinceClr_r <= '0;
		else if (coreReset_r || svcClr)
			sinceClr_r <= '0;
		else if (!(&sinceClr_r))
			sinceClr_r <= sinceClr_r + 23'd1;
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstSync_b);

	chk_pin_hold_low: assert property (
		state_r == ST_HOLD && !rstPinIn |=> coreReset_r && state_r == ST_HOLD)
		else $error("Reset released while pin still low");
	chk_drive_four: assert property (
		$fell(rstPinOe_b_r) |-> !rstPinOe_b_r [*4] ##1 rstPinOe_b_r)
		else $error("Pin drive not four cycles");
	chk_sample_ext: assert property (
		$rose(rstPinOe_b_r) ##1 !rstPinIn |=> cause_r == CAUSE_PIN)
		else $error("Low pin after release not taken as external");
	chk_wd_not_short: assert property (
		wdTimeout |-> sinceClr_r >= {1'b0, rateDiv, 15'h0000})
		else $error("Watchdog timed out early");
	chk_service_pair: assert property (
		!coreReset_r && wdCnt_r != 7'd0 && !(tick && wdCnt_r < rateDiv)
		##1 wdCnt_r == 7'd0 |-> $past(svcClr))
		else $error("Watchdog cleared without service pair");
	chk_opt_lock: assert property (
		optWr && !protOpen |=>
		(sysOptions_r & OPT_PROT_MASK) == $past(sysOptions_r & OPT_PROT_MASK))
		else $error("Protected option bits changed");
	chk_force_sticky: assert property (
		sysOptions_r[OPT_CLK_MONITOR_FORCE] && !coreReset_r |=> sysOptions_r[OPT_CLK_MONITOR_FORCE])
		else $error("Monitor force cleared without reset");
	chk_mon_reset: assert property (
		state_r == ST_RUN && rstPinIn && monFail |=>
		state_r == ST_DRIVE && cause_r == CAUSE_CMON)
		else $error("Monitor failure did not start reset");
	chk_reset_opts: assert property (
		coreReset_r |=> sysOptions_r == OPT_RST)
		else $error("Options not at reset value");
	chk_wd_vector: assert property (
		state_r == ST_RUN && rstPinIn && !monFail && wdTimeout |=>
		##[1:8] resetVector_r == vecFor(CAUSE_WDOG, specLatched_r))
		else $error("Watchdog vector wrong");

	cov_wd_reset: cover property (wdTimeout && state_r == ST_RUN);
	cov_ext_sample: cover property (state_r == ST_GAP ##1 state_r == ST_EXT);
	cov_mon_reset: cover property (monFail && state_r == ST_RUN);
	cov_service: cover property (svcArm ##[1:20] svcClr);

endmodule // rsw_reset_ctrl

// >>> tb/rsw_supervisor_model.sv
`timescale 1ns/1ps
module rsw_supervisor_model (
	// Bench control
	input wire logic holdLow,
	// Open-drain pin
	input wire logic rstPinOut,
	input wire logic rstPinOe_b,
	output logic rstPinIn
);
	// Pull-up with a fast rise, no slow RC delay
	assign rstPinIn = !holdLow && (rstPinOe_b || rstPinOut);
endmodule // rsw_supervisor_model

// >>> tb/rsw_reset_ctrl_tb.sv
`timescale 1ns/1ps
module rsw_reset_ctrl_tb;
	import rsw_pkg::*;
	logic core_clk, rst_b, regWr, regRd, holdLow, rstPinIn;
	logic rstPinOut_r, rstPinOe_b_r, clkMonRcExpired, coreReset_r;
	logic wdDisCfg, specMode;
	logic [7:0] regAddr, regWrData, regRdData_r, sysOptions_r, r;
	logic [15:0] resetVector_r;
	logic [7:0] expQ[$];
	logic [31:0] rnd = 32'd60;
	logic rdDly = 1'b0;
	int err_total = 0;
	int n_compared = 0;
	int cycles = 0;
	int cnt;

	rsw_reset_ctrl rsw_reset_ctrl_inst (.core_clk(core_clk), .rst_b(rst_b),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData_r(regRdData_r), .rstPinIn(rstPinIn),
		.rstPinOut_r(rstPinOut_r), .rstPinOe_b_r(rstPinOe_b_r),
		.wdDisableCfg(wdDisCfg), .specialMode(specMode),
		.clkMonRcExpired(clkMonRcExpired), .coreReset_r(coreReset_r),
		.resetVector_r(resetVector_r), .sysOptions_r(sysOptions_r));

	rsw_supervisor_model rsw_supervisor_model_inst (.holdLow(holdLow),
		.rstPinOut(rstPinOut_r), .rstPinOe_b(rstPinOe_b_r),
		.rstPinIn(rstPinIn));

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	function automatic logic [31:0] xs();
		rnd ^= rnd << 13;
		rnd ^= rnd >> 17;
		rnd ^= rnd << 5;
		return rnd;
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Read results come off the queue in issue order
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 90000)
		begin
			err_total++;
			report_and_stop();
		end
		if (rdDly)
			check({8'h00, regRdData_r}, {8'h00, expQ.pop_front()});
		rdDly <= regRd;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		regRd <= 1'b1;
		regAddr <= a;
		expQ.push_back(e);
		@(posedge core_clk);
		regRd <= 1'b0;
	endtask

	task automatic waitReset(input logic lvl, input int limit);
		cnt = 0;
		while (coreReset_r !== lvl && cnt < limit)
		begin
			@(posedge core_clk);
			#1;
			cnt++;
		end
	endtask

	// Pin drive window and sample point after a sensed cause
	task automatic pinSeq(input logic [15:0] vec);
		@(posedge core_clk);
		clkMonRcExpired <= 1'b0;
		#1;
		check({15'h0, coreReset_r}, 16'h1);
		check(resetVector_r, vec);
		repeat (4)
		begin
			check({15'h0, rstPinOe_b_r}, 16'h0);
			@(posedge core_clk);
			#1;
		end
		check({15'h0, rstPinOe_b_r}, 16'h1);
		repeat (2) @(posedge core_clk);
		#1;
	endtask

	initial
	begin
		rst_b = 1'b0;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
		holdLow = 1'b0;
		clkMonRcExpired = 1'b0;
		wdDisCfg = 1'b0;
		specMode = 1'b0;
		repeat (12) @(posedge core_clk);
		rst_b <= 1'b1;
		waitReset(1'b0, 4200);
		check(16'(cnt >= 4064), 16'h1);
		check(resetVector_r, VEC_NORM);
		rd(OPT_OFS, OPT_RST);
		rd(STAT_OFS, 8'h04);
		rd(SVC_OFS, 8'h00);
		rd(8'h20, 8'h00);
		$display("test power-on done");
		wr(OPT_OFS, 8'h0d);
		r = xs();
		wr(OPT_OFS, r);
		rd(OPT_OFS, 8'h05 | (r & 8'hc8));
		wr(SVC_OFS, SVC_ARM);
		rd(STAT_OFS, 8'h1c);
		wr(SVC_OFS, SVC_CLR);
		rd(STAT_OFS, 8'h14);
		$display("test options and service done");
		@(posedge core_clk);
		clkMonRcExpired <= 1'b1;
		pinSeq(16'hfffc);
		check({15'h0, coreReset_r}, 16'h0);
		check({8'h00, sysOptions_r}, {8'h00, OPT_RST});
		rd(STAT_OFS, 8'h06);
		$display("test clock monitor done");
		@(posedge core_clk);
		holdLow <= 1'b1;
		pinSeq(16'hfffe);
		check({15'h0, coreReset_r}, 16'h1);
		holdLow <= 1'b0;
		waitReset(1'b0, 3);
		check({15'h0, coreReset_r}, 16'h0);
		rd(STAT_OFS, 8'h05);
		$display("test external pin done");
		wr(SVC_OFS, SVC_ARM);
		wr(SVC_OFS, SVC_CLR);
		waitReset(1'b1, 70000);
		check(16'(cnt >= 32768 && cnt <= 65540), 16'h1);
		check(resetVector_r, 16'hfffa);
		waitReset(1'b0, 10);
		rd(STAT_OFS, 8'h07);
		rd(OPT_OFS, OPT_RST);
		repeat (2) @(posedge core_clk);
		$display("test watchdog done");
		// Power-on again with the pin held low and the strap set
		wdDisCfg <= 1'b1;
		holdLow <= 1'b1;
		rst_b <= 1'b0;
		repeat (12) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (4100) @(posedge core_clk);
		#1;
		check({15'h0, coreReset_r}, 16'h1);
		holdLow <= 1'b0;
		waitReset(1'b0, 3);
		check({15'h0, coreReset_r}, 16'h0);
		check(resetVector_r, VEC_NORM);
		// Strap change must wait for the next reset
		wdDisCfg <= 1'b0;
		rd(STAT_OFS, 8'h00);
		$display("test held power-on done");
		specMode <= 1'b1;
		@(posedge core_clk);
		holdLow <= 1'b1;
		pinSeq(16'hfffe);
		holdLow <= 1'b0;
		waitReset(1'b0, 3);
		check(resetVector_r, VEC_SPEC);
		rd(STAT_OFS, 8'h01);
		wr(TEST_OFS, 8'h00);
		rd(STAT_OFS, 8'h05);
		wr(OPT_OFS, 8'h0a);
		// Monitor off before clocks halt, back on after
		wr(OPT_OFS, 8'h02);
		clkMonRcExpired <= 1'b1;
		repeat (3) @(posedge core_clk);
		clkMonRcExpired <= 1'b0;
		#1;
		check({15'h0, coreReset_r}, 16'h0);
		wr(OPT_OFS, 8'h0a);
		rd(OPT_OFS, 8'h0a);
		$display("test special mode done");
		report_and_stop();
	end
endmodule // rsw_reset_ctrl_tb
